// >>> design/sel_pkg.sv
// package for the serial configuration word loader
// assumes a 100 MHz pclk domain and a 32-bit apb register port
package sel_pkg;
    // clock and serial timing
    localparam int SEL_PCLK_NS = 10;
    localparam int SEL_SCK_HALF_NS = 40;
    localparam int SEL_SCK_HALF_CYC = SEL_SCK_HALF_NS / SEL_PCLK_NS;
    localparam int SEL_SLOT_CYC = 2 * SEL_SCK_HALF_CYC;
    localparam int SEL_SETTLE_CYC = 4;
    // serial command: start bit, read opcode, word address
    localparam logic [7:0] SEL_READ_CMD = 8'hc0;
    localparam logic [5:0] SEL_CMD_BITS = 6'h08;
    localparam logic [5:0] SEL_RECV_BITS = 6'h31;
    localparam int SEL_WORD_BITS = 16;
    localparam int SEL_GANG_BIT = 14;
    localparam logic [1:0] SEL_WORD_OPTION = 2'h0;
    localparam logic [1:0] SEL_WORD_VENDOR = 2'h1;
    localparam logic [1:0] SEL_WORD_PRODUCT = 2'h2;
    // built-in identifiers (values arbitrary)
    localparam logic [15:0] SEL_DEF_VENDOR = 16'h1234;
    localparam logic [15:0] SEL_DEF_PRODUCT = 16'h5678;
    // register byte offsets
    localparam logic [11:0] SEL_OFS_CTRL = 12'h000;
    localparam logic [11:0] SEL_OFS_STATUS = 12'h004;
    localparam logic [11:0] SEL_OFS_IDENT = 12'h008;
    // field positions and the control reset value
    localparam int SEL_CTRL_HOLD = 0;
    localparam int SEL_ST_DONE = 0;
    localparam int SEL_ST_BUSY = 1;
    localparam int SEL_ST_EXT = 2;
    localparam int SEL_ST_GANG = 3;
    localparam logic SEL_CTRL_RESET = 1'b0;

    typedef enum {SEL_WAIT, SEL_SEND, SEL_RECV, SEL_DRAIN, SEL_DONE} sel_state_e;

    typedef struct packed {
        logic [1:0] idx;
        logic [15:0] data;
    } sel_word_s;

    typedef struct packed {
        logic paddr_ok;
        logic [11:0] paddr;
    } sel_addr_s;
endpackage : sel_pkg

// >>> design/sel_loader.sv
// power-on loader of three configuration words from a serial eeprom
// assumes the eeprom chip select follows system reset and data/q share one wire
// Operation
// - one read after reset, only when select low
// - send start 1, opcode 10, address 00000
// - release data line after address is sent
// - capture dummy 0 then three words msb-first
// - drive serial clock, sample away from rise
// - tristate both lines with pulldowns after load
// - gang from word0 d14, vendor w1, product w2
// - pulldowns on when select low, off otherwise
module sel_loader
    import sel_pkg::*;
(
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // eeprom pins and strap
    input wire logic ext_config_select_n,
    input wire logic cfg_serial_data_i,
    output logic cfg_serial_data_o,
    output logic cfg_serial_data_oe,
    output logic cfg_serial_clock_o,
    output logic cfg_serial_clock_oe,
    output logic cfg_pulldown_en,
    // word stream out of the buffer
    output sel_pkg::sel_word_s strm_word,
    output logic strm_valid,
    input wire logic strm_ready,
    // loaded configuration
    output logic [15:0] vendor_ident_word,
    output logic [15:0] product_ident_word,
    output logic gang_power,
    output logic cfg_ready
);
    import sel_pkg::*;

    sel_state_e state;
    logic [1:0] sel_meta;
    logic [1:0] dat_meta;
    logic sel_n_s;
    logic dat_s;
    logic [3:0] settle;
    logic [2:0] phase;
    logic [5:0] bitcnt;
    logic [15:0] shreg;
    logic [1:0] widx;
    logic ext_mode;
    logic ctrl_hold;
    logic skid_v;
    sel_word_s skid;
    sel_word_s next_word;
    // first two words wait here until the third arrives
    logic gang_stage;
    logic [15:0] vendor_stage;
    logic [31:0] stat_word;

    // pins from outside pass two flops; first stage read only by second
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_meta <= 2'h3;
            dat_meta <= 2'h0;
        end
        else
        begin
            sel_meta <= {sel_meta[0], ext_config_select_n};
            dat_meta <= {dat_meta[0], cfg_serial_data_i};
        end
    end
    assign sel_n_s = sel_meta[1];
    assign dat_s = dat_meta[1];

    // bit slot timing: low half then high half of the serial clock
    wire slot_end = (phase == 3'(SEL_SLOT_CYC - 1));
    wire rise_now = (phase == 3'(SEL_SCK_HALF_CYC - 1));
    wire fill_ready = !skid_v;
    wire word_end = (state == SEL_RECV) && (bitcnt != 6'h00)
        && (bitcnt[3:0] == 4'h0);
    // a finished word waits at the end of high phase while the buffer is full
    wire stall = slot_end && word_end && !fill_ready;
    wire advance = !stall;
    wire push = slot_end && word_end && fill_ready;
    wire [15:0] cap_word = {shreg[14:0], dat_s};
    wire pop = strm_valid && strm_ready;
    wire pop_last = pop && (strm_word.idx == SEL_WORD_PRODUCT);
    // stream entry built once so both buffer stages load the same value
    assign next_word = {widx, cap_word};

    // sequencer; the clock idles low outside the read
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= SEL_WAIT;
            settle <= 4'h0;
            phase <= 3'h0;
            bitcnt <= 6'h00;
            shreg <= 16'h0000;
            widx <= 2'h0;
            ext_mode <= 1'b0;
            cfg_serial_data_o <= 1'b0;
            cfg_serial_data_oe <= 1'b0;
            cfg_serial_clock_o <= 1'b0;
            cfg_serial_clock_oe <= 1'b0;
            cfg_pulldown_en <= 1'b0;
        end
        else
        begin
            unique case (state)
                SEL_WAIT:
                begin
                    // strap sampled once, after the synchroniser has settled
                    if (settle != 4'(SEL_SETTLE_CYC))
                        settle <= settle + 4'h1;
                    else if (!ctrl_hold)
                    begin
                        ext_mode <= !sel_n_s;
                        cfg_pulldown_en <= !sel_n_s;
                        cfg_serial_clock_oe <= !sel_n_s;
                        cfg_serial_data_oe <= !sel_n_s;
                        phase <= 3'h0;
                        bitcnt <= 6'h00;
                        state <= sel_n_s ? SEL_DRAIN : SEL_SEND;
                    end
                end
                SEL_SEND:
                begin
                    phase <= phase + 3'h1;
                    // data changes one cycle after the fall so it is stable at the rise
                    if (phase == 3'h0)
                        cfg_serial_data_o <= SEL_READ_CMD[3'(7 - bitcnt[2:0])];
                    if (rise_now)
                        cfg_serial_clock_o <= 1'b1;
                    if (slot_end)
                    begin
                        cfg_serial_clock_o <= 1'b0;
                        if (bitcnt == SEL_CMD_BITS - 6'h01)
                        begin
                            bitcnt <= 6'h00;
                            cfg_serial_data_oe <= 1'b0;
                            cfg_serial_data_o <= 1'b0;
                            state <= SEL_RECV;
                        end
                        else
                            bitcnt <= bitcnt + 6'h01;
                    end
                end
                SEL_RECV:
                begin
                    // a stall freezes the phase with the clock high, so the eeprom holds its bit
                    if (advance)
                        phase <= phase + 3'h1;
                    if (rise_now)
                        cfg_serial_clock_o <= 1'b1;
                    if (slot_end && advance)
                    begin
                        // sampled at end of high half, far from the change at the rise
                        shreg <= cap_word;
                        cfg_serial_clock_o <= 1'b0;
                        if (push)
                            widx <= widx + 2'h1;
                        if (bitcnt == SEL_RECV_BITS - 6'h01)
                        begin
                            cfg_serial_clock_oe <= 1'b0;
                            state <= SEL_DRAIN;
                        end
                        else
                            bitcnt <= bitcnt + 6'h01;
                    end
                end
                SEL_DRAIN:
                begin
                    // with the strap low, finish only once the product word has left the buffer; strap high finishes at once
                    if (!ext_mode || pop_last)
                        state <= SEL_DONE;
                end
                SEL_DONE:
                begin
                    // terminal until reset, so a later hold write cannot restart
                    cfg_serial_clock_oe <= 1'b0;
                end
            endcase
        end
    end

    // two-entry skid buffer; output stage and skid stage are both flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strm_valid <= 1'b0;
            strm_word <= '0;
            skid_v <= 1'b0;
            skid <= '0;
        end
        else if (!strm_valid || strm_ready)
        begin
            strm_valid <= skid_v || push;
            strm_word <= skid_v ? skid : next_word;
            skid_v <= 1'b0;
        end
        // the skid stage fills only while the output stage is stalled
        else if (push)
        begin
            skid_v <= 1'b1;
            skid <= next_word;
        end
    end

    // configuration results change only once, at completion
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vendor_ident_word <= 16'h0000;
            product_ident_word <= 16'h0000;
            gang_power <= 1'b0;
            cfg_ready <= 1'b0;
            gang_stage <= 1'b0;
            vendor_stage <= 16'h0000;
        end
        // strap high: built-in identifiers and the option pin level
        else if (state == SEL_DRAIN && !ext_mode)
        begin
            vendor_ident_word <= SEL_DEF_VENDOR;
            product_ident_word <= SEL_DEF_PRODUCT;
            gang_power <= dat_s;
            cfg_ready <= 1'b1;
        end
        else if (pop && !cfg_ready)
        begin
            // earlier words wait in staging so no partial set is ever shown
            unique case (strm_word.idx)
                SEL_WORD_OPTION: gang_stage <= strm_word.data[SEL_GANG_BIT];
                SEL_WORD_VENDOR: vendor_stage <= strm_word.data;
                SEL_WORD_PRODUCT:
                begin
                    product_ident_word <= strm_word.data;
                    vendor_ident_word <= vendor_stage;
                    gang_power <= gang_stage;
                    cfg_ready <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    // apb decode; one wait-free access phase, answer registered in setup
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire hit_ctrl = (paddr == SEL_OFS_CTRL);
    wire hit_stat = (paddr == SEL_OFS_STATUS);
    wire hit_ident = (paddr == SEL_OFS_IDENT);
    wire mapped = hit_ctrl || hit_stat || hit_ident;
    wire busy = (state == SEL_SEND) || (state == SEL_RECV);
    // status fields sit at their package positions; unused bits read as zero
    always_comb
    begin
        stat_word = 32'h00000000;
        stat_word[SEL_ST_DONE] = cfg_ready;
        stat_word[SEL_ST_BUSY] = busy;
        stat_word[SEL_ST_EXT] = ext_mode;
        stat_word[SEL_ST_GANG] = gang_power;
    end
    wire [31:0] rd_mux = hit_ctrl ? {31'h0, ctrl_hold}
        : hit_stat ? stat_word
        : hit_ident ? {product_ident_word, vendor_ident_word} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            ctrl_hold <= SEL_CTRL_RESET;
        end
        else
        begin
            // unmapped offsets raise pslverr; writes to read-only words drop quietly
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? rd_mux : 32'h00000000;
            // hold only delays the start; it cannot cause a second read
            if (access && pwrite && hit_ctrl)
                ctrl_hold <= pwdata[SEL_CTRL_HOLD];
        end
    end
endmodule : sel_loader

// >>> dv/sel_eeprom_model.sv
// behavioural serial eeprom on the shared data wire
// assumes chip select follows system reset and the bench resolves the wire
module sel_eeprom_model
    import sel_pkg::*;
(
    // serial pins
    input wire logic sclk,
    input wire logic cs_rst_n,
    input wire logic sdata,
    // words 0..2, word 0 in the top bits
    input wire logic [47:0] mem,
    // output drive and captured command
    output logic q,
    output logic q_oe,
    output logic [7:0] cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [48:0] sh;
    logic rel;
    int n;

    // drive only between the ninth rise and the fall after the last bit
    assign q_oe = n > 8 && !rel;

    // command shifts in, then dummy and words shift out on each rise
    always @(posedge sclk or negedge cs_rst_n)
    begin
        if (!cs_rst_n)
        begin
            n <= 0;
            cmd <= 8'h00;
            q <= 1'b0;
        end
        else if (n < 8)
        begin
            cmd <= {cmd[6:0], sdata};
            sh <= {1'b0, mem}; // dummy zero, then msb first
            n <= n + 1;
        end
        else if (n < 57)
        begin
            q <= sh[48]; // output changes on the rise
            sh <= sh << 1; // address advances by itself
            n <= n + 1;
        end
    end

    // release on the fall after the last bit
    always @(negedge sclk or negedge cs_rst_n)
    begin
        if (!cs_rst_n)
            rel <= 1'b0;
        else
            rel <= n >= 57;
    end
endmodule : sel_eeprom_model

// >>> dv/sel_loader_checker.sv
// assertions on the loader's serial pins, word stream and results
// assumes binding into sel_loader with pclk and active-low presetn
module sel_checker
    import sel_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // strap and serial pins
    input wire logic ext_config_select_n,
    input wire logic cfg_serial_data_o,
    input wire logic cfg_serial_data_oe,
    input wire logic cfg_serial_clock_o,
    input wire logic cfg_serial_clock_oe,
    input wire logic cfg_pulldown_en,
    // stream and results
    input wire sel_pkg::sel_word_s strm_word,
    input wire logic strm_valid,
    input wire logic strm_ready,
    input wire logic [15:0] vendor_ident_word,
    input wire logic [15:0] product_ident_word,
    input wire logic cfg_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // long high phase keeps sampling well away from the rise
    sequence s_high4;
        cfg_serial_clock_o [*4];
    endsequence
    sequence s_quiet;
        !cfg_serial_data_oe && !cfg_serial_clock_oe;
    endsequence

    a_clock_high: assert property ($rose(cfg_serial_clock_o) |-> s_high4)
        else $error("serial clock high phase too short");
    a_cmd_stable: assert property (cfg_serial_data_oe && cfg_serial_clock_o
        |-> $stable(cfg_serial_data_o))
        else $error("command bit changed while clock high");
    a_strap_quiet: assert property (ext_config_select_n
        |-> s_quiet ##0 !cfg_pulldown_en)
        else $error("serial pins active with strap high");
    a_idle_done: assert property (cfg_ready
        |-> s_quiet ##0 cfg_pulldown_en == !ext_config_select_n)
        else $error("serial pins not released after load");
    a_ids_held: assert property (!cfg_ready
        |-> vendor_ident_word == 16'h0000 && product_ident_word == 16'h0000)
        else $error("identifiers shown before load done");
    a_ids_default: assert property (cfg_ready && ext_config_select_n
        |-> vendor_ident_word == SEL_DEF_VENDOR && product_ident_word == SEL_DEF_PRODUCT)
        else $error("built-in identifiers wrong");
    a_word_hold: assert property (strm_valid && !strm_ready
        |=> strm_valid && $stable(strm_word))
        else $error("stream word lost while stalled");
    a_ready_once: assert property (cfg_ready |=> cfg_ready)
        else $error("load done dropped");
endmodule : sel_checker

// >>> dv/tb_serial_eeprom_id_loader.sv
// bench for the configuration loader: eeprom model, stalls, apb reads
// assumes the package, eeprom model and checker compile first
module tb_serial_eeprom_id_loader;
    timeunit 1ns;
    timeprecision 1ps;
    import sel_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, strm_ready = 0;
    logic ext_config_select_n = 0, pin_lvl = 0, pready, pslverr, q, q_oe;
    logic cfg_serial_data_i, cfg_serial_data_o, cfg_serial_data_oe, cfg_serial_clock_o;
    logic cfg_serial_clock_oe, cfg_pulldown_en, strm_valid, gang_power, cfg_ready;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, seed = 32'he25c;
    logic [15:0] vendor_ident_word, product_ident_word;
    logic [47:0] mem;
    logic [7:0] cmd;
    sel_word_s strm_word;
    sel_word_s got [$];
    int err_count = 0, tests_run = 0, cyc = 0;

    // wire: driver, else eeprom, else pulldown or board level
    assign cfg_serial_data_i = cfg_serial_data_oe ? cfg_serial_data_o : q_oe ? q :
        cfg_pulldown_en ? 1'b0 : pin_lvl;

    sel_loader u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ext_config_select_n, .cfg_serial_data_i, .cfg_serial_data_o,
        .cfg_serial_data_oe, .cfg_serial_clock_o, .cfg_serial_clock_oe, .cfg_pulldown_en,
        .strm_word, .strm_valid, .strm_ready, .vendor_ident_word, .product_ident_word,
        .gang_power, .cfg_ready);
    sel_eeprom_model u_rom (.sclk(cfg_serial_clock_oe & cfg_serial_clock_o), .cs_rst_n(presetn),
        .sdata(cfg_serial_data_i), .mem, .q, .q_oe, .cmd);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [15:0] ew(input int i);
        return mem[47 - 16 * i -: 16];
    endfunction : ew

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic run(input logic s, input logic p, input int lim);
        presetn <= 1'b0;
        ext_config_select_n <= s;
        pin_lvl <= p;
        repeat (8) @(posedge pclk);
        got.delete();
        presetn <= 1'b1;
        for (int i = 0; i < lim && cfg_ready !== 1'b1; i++)
        begin
            @(posedge pclk);
        end
    endtask : run

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // receiver stalls long at first so the buffer fills, then randomly; hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        strm_ready <= cyc > 1500 && rnd() % 3 != 0;
        if (strm_valid === 1'b1 && strm_ready === 1'b1)
            got.push_back(strm_word);
        if (cyc == 15000)
        begin
            err_count++;
            conclude();
        end
    end

    initial
    begin
        logic [31:0] r, rd;
        logic er;
        r = rnd();
        mem = {r[15:0], rnd()};
        run(1'b0, 1'b0, 300);
        run(1'b0, 1'b0, 4000);
        repeat (600) @(posedge pclk);
        check("cmd", cmd, {1'b1, 2'b10, 5'b00000});
        check("count", got.size(), 3);
        for (int i = 0; i < 3; i++)
        begin
            check("idx", got[i].idx, i);
            check("word", got[i].data, ew(i));
        end
        check("gang", gang_power, mem[46]);
        check("pins", {cfg_serial_data_oe, cfg_serial_clock_oe, cfg_pulldown_en}, 1);
        check("vid", vendor_ident_word, ew(1));
        check("pid", product_ident_word, ew(2));
        apb(1'b1, SEL_OFS_IDENT, rnd(), rd, er);
        apb(1'b0, SEL_OFS_IDENT, 32'h00000000, rd, er);
        check("ident", rd, {ew(2), ew(1)});
        apb(1'b0, SEL_OFS_STATUS, 32'h00000000, rd, er);
        check("status", rd, {28'h0000000, mem[46], 3'h5});
        apb(1'b1, SEL_OFS_CTRL, 32'h00000001, rd, er);
        apb(1'b0, SEL_OFS_CTRL, 32'h00000000, rd, er);
        check("hold", rd, 1);
        apb(1'b0, 12'h00c, 32'h00000000, rd, er);
        check("slverr", er, 1);
        $display("test eeprom load done");
        run(1'b1, 1'b1, 4000);
        check("vendor", vendor_ident_word, SEL_DEF_VENDOR);
        check("product", product_ident_word, SEL_DEF_PRODUCT);
        check("option", gang_power, 1);
        check("none", got.size(), 0);
        check("off", {cfg_serial_data_oe, cfg_serial_clock_oe, cfg_pulldown_en}, 0);
        $display("test strap default done");
        conclude();
    end
endmodule : tb_serial_eeprom_id_loader

bind sel_loader sel_checker u_chk (.pclk, .presetn, .ext_config_select_n, .cfg_serial_data_o,
    .cfg_serial_data_oe, .cfg_serial_clock_o, .cfg_serial_clock_oe, .cfg_pulldown_en,
    .strm_word, .strm_valid, .strm_ready, .vendor_ident_word, .product_ident_word, .cfg_ready);
